// ---- inc/dsp_agu_pkg.sv ----
// Shared constants and carriers of the DSP address generator
package dsp_agu_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int REG_ADDR_W_DEF = 8;
	localparam int PTR_W = 32;
	localparam int HALF_W = 16;
	localparam int NUM_PTR = 8;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_PTR_BASE = 8'h00;
	localparam logic [7:0] OFF_WRAP_BOUNDS = 8'h20;
	localparam logic [7:0] OFF_STATUS_WORD = 8'h24;
	// ----------------------------------------------------------------
	// Entry of each general register in the pointer file (Rn - 2)
	// ----------------------------------------------------------------
	localparam logic [2:0] S_PTR_BASE = 3'h0;
	localparam logic [2:0] X_PTR_BASE = 3'h2;
	localparam logic [2:0] Y_PTR_BASE = 3'h4;
	localparam logic [2:0] X_INDEX_IDX = 3'h6;
	localparam logic [2:0] Y_INDEX_IDX = 3'h7;
	localparam logic [2:0] S_STEP_IDX = 3'h6;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int WRAP_END_LSB = 16;
	localparam int WRAP_START_LSB = 0;
	localparam int STAT_XWRAP_BIT = 0;
	localparam int STAT_YWRAP_BIT = 1;
	// ----------------------------------------------------------------
	// Reset values and steps
	// ----------------------------------------------------------------
	localparam logic [31:0] PTR_RST = 32'h0000_0000;
	localparam logic [31:0] WRAP_BOUNDS_RST = 32'h0000_0000;
	localparam logic WRAP_EN_RST = 1'b0;
	localparam logic [15:0] XY_STEP = 16'h0002;
	localparam logic [31:0] STEP_WORD = 32'h0000_0002;
	localparam logic [31:0] STEP_LONG = 32'h0000_0004;
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_NONE, MODE_INDEX, MODE_INC, MODE_DEC
	} updMode_t;
	typedef struct packed {
		logic valid;
		logic paired;
		logic xSel;
		logic ySel;
		logic [1:0] sSel;
		updMode_t mode;
		logic isLong;
		logic isStore;
	} xferReq_t;
	typedef struct packed {
		logic xyValid;
		logic [15:0] xAddr;
		logic [15:0] yAddr;
		logic sValid;
		logic [31:0] sAddr;
		logic sLong;
		logic sStore;
	} xferAddr_t;
endpackage

// ---- verilog/dsp_address_generator.sv ----
// Address generator for paired X/Y and single DSP data transfers
`timescale 1ns/1ns

// Functional notes
// - X pointer from R4 or R5, Y pointer from R6 or R7, per request.
// - R8 indexes the X pointer, R9 indexes the Y pointer.
// - Paired increment adds 2 to both pointers; no-update leaves both.
// - Paired index-add adds each index to its pointer after transfer.
// - Paired transfers are always 16-bit word accesses.
// - X/Y addresses use pointer bits 15..1; bit 0 is forced low.
// - Paired updates touch only the low pointer half; upper half kept.
// - X and Y addresses leave together on separate paths, no main bus.
// - Single pointer is one of R2 to R5, per request.
// - Single index-add adds R8 to the pointer after transfer.
// - Single increment adds 2 or 4 afterwards; no-update leaves it.
// - Single decrement subtracts 2 or 4 first and uses that address.
// - Single transfers use the full main path and wait on main bus.
// - X or Y wrap enable selects wrapped pointer; never both at once.
// - Single-transfer updates never wrap.
// - Wrap when low pointer half equals end bound; load start instead.
// - A wrap rewrites only pointer bits 15..1 from the start bound.
// - Only an exact end match wraps; stepping past it does not.
// - Circular buffer spans at most 64 kbytes.
// - Wrap bounds register holds start and end, loaded by software.
module dsp_address_generator #(
	parameter int REG_ADDR_W = dsp_agu_pkg::REG_ADDR_W_DEF
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Register port
	input wire logic [REG_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRData,
	// Transfer requests
	input wire dsp_agu_pkg::xferReq_t xferReq,
	output logic xferReady,
	input wire logic mainBusy,
	// Generated addresses
	output dsp_agu_pkg::xferAddr_t xferAddr
);
	import dsp_agu_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [31:0] ptr [NUM_PTR];
	logic [31:0] wrapBounds;
	logic xWrapEn;
	logic yWrapEn;

	logic [2:0] xIdx;
	logic [2:0] yIdx;
	logic [2:0] sIdx;
	logic [31:0] xPtr;
	logic [31:0] yPtr;
	logic [31:0] sPtr;
	logic [15:0] wrapStart;
	logic [15:0] wrapEnd;
	logic xHit;
	logic yHit;
	logic accept;
	logic doXY;
	logic doS;
	logic xyUpd;
	logic sUpd;
	logic [31:0] next_x;
	logic [31:0] next_y;
	logic [31:0] next_s;
	logic [31:0] sStep;
	logic [31:0] sEa;
	logic ptrSpace;

	generate
		if (REG_ADDR_W < 6) begin : g_chk
			$error("REG_ADDR_W too small for the register map");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Operand selection
	// ----------------------------------------------------------------
	assign xIdx = X_PTR_BASE + {2'b00, xferReq.xSel};
	assign yIdx = Y_PTR_BASE + {2'b00, xferReq.ySel};
	assign sIdx = S_PTR_BASE + {1'b0, xferReq.sSel};
	assign xPtr = ptr[xIdx];
	assign yPtr = ptr[yIdx];
	assign sPtr = ptr[sIdx];
	assign wrapStart = wrapBounds[WRAP_START_LSB +: HALF_W];
	assign wrapEnd = wrapBounds[WRAP_END_LSB +: HALF_W];
	assign xHit = xWrapEn && (xPtr[15:0] == wrapEnd);
	assign yHit = yWrapEn && (yPtr[15:0] == wrapEnd);

	// Single transfers wait while the main bus is taken
	assign xferReady = xferReq.paired || !mainBusy;
	assign accept = xferReq.valid && xferReady;
	assign doXY = accept && xferReq.paired;
	assign doS = accept && !xferReq.paired;
	assign xyUpd = doXY && (xferReq.mode == MODE_INDEX
		|| xferReq.mode == MODE_INC);
	assign sUpd = doS && (xferReq.mode != MODE_NONE);

	// ----------------------------------------------------------------
	// Paired update: low half only, exact end match wraps
	// ----------------------------------------------------------------
	function automatic logic [15:0] xyNext(
		input logic [15:0] cur,
		input logic [15:0] idx,
		input updMode_t mode,
		input logic hit,
		input logic [15:0] start
	);
		logic [15:0] res;
		res = cur;
		if (hit) begin
			res = {start[15:1], cur[0]};
		end else begin
			case (mode)
				MODE_INDEX: res = cur + idx;
				MODE_INC: res = cur + XY_STEP;
				default: res = cur;
			endcase
		end
		return res;
	endfunction

	always_comb begin
		next_x = {xPtr[31:16], xyNext(xPtr[15:0],
			ptr[X_INDEX_IDX][15:0], xferReq.mode, xHit,
			wrapStart)};
		next_y = {yPtr[31:16], xyNext(yPtr[15:0],
			ptr[Y_INDEX_IDX][15:0], xferReq.mode, yHit,
			wrapStart)};
	end

	// ----------------------------------------------------------------
	// Single update: full width, never wraps
	// ----------------------------------------------------------------
	assign sStep = xferReq.isLong ? STEP_LONG : STEP_WORD;
	assign sEa = (xferReq.mode == MODE_DEC) ? (sPtr - sStep)
		: sPtr;

	always_comb begin
		case (xferReq.mode)
			MODE_INDEX: next_s = sPtr + ptr[S_STEP_IDX];
			MODE_INC: next_s = sPtr + sStep;
			MODE_DEC: next_s = sEa;
			default: next_s = sPtr;
		endcase
	end

	// ----------------------------------------------------------------
	// Pointer file: transfer updates win over register writes
	// ----------------------------------------------------------------
	assign ptrSpace = (regAddr[REG_ADDR_W-1:5] == '0)
		&& (regAddr[1:0] == 2'b00);

	generate
		for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					ptr[i] <= PTR_RST;
				end else if (xyUpd && xIdx == 3'(i)) begin
					ptr[i] <= next_x;
				end else if (xyUpd && yIdx == 3'(i)) begin
					ptr[i] <= next_y;
				end else if (sUpd && sIdx == 3'(i)) begin
					ptr[i] <= next_s;
				end else if (regWr && ptrSpace
					&& regAddr[4:2] == 3'(i)) begin
					ptr[i] <= regWData;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Wrap bounds and wrap enables
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wrapBounds <= WRAP_BOUNDS_RST;
		end else if (regWr && regAddr == REG_ADDR_W'(OFF_WRAP_BOUNDS)) begin
			wrapBounds <= regWData;
		end
	end

	// A write asking for both enables is refused whole
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			xWrapEn <= WRAP_EN_RST;
			yWrapEn <= WRAP_EN_RST;
		end else if (regWr && regAddr == REG_ADDR_W'(OFF_STATUS_WORD)
			&& !(regWData[STAT_XWRAP_BIT] && regWData[STAT_YWRAP_BIT])) begin
			xWrapEn <= regWData[STAT_XWRAP_BIT];
			yWrapEn <= regWData[STAT_YWRAP_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Register read, one cycle later
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			regRData <= '0;
		end else if (regRd) begin
			if (ptrSpace) begin
				regRData <= ptr[regAddr[4:2]];
			end else if (regAddr == REG_ADDR_W'(OFF_WRAP_BOUNDS)) begin
				regRData <= wrapBounds;
			end else if (regAddr == REG_ADDR_W'(OFF_STATUS_WORD)) begin
				regRData <= '0;
				regRData[STAT_XWRAP_BIT] <= xWrapEn;
				regRData[STAT_YWRAP_BIT] <= yWrapEn;
			end else begin
				regRData <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Address outputs
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			xferAddr <= '0;
		end else begin
			xferAddr.xyValid <= doXY;
			xferAddr.sValid <= doS;
			if (doXY) begin
				xferAddr.xAddr <= {xPtr[15:1], 1'b0};
				xferAddr.yAddr <= {yPtr[15:1], 1'b0};
			end
			if (doS) begin
				xferAddr.sAddr <= sEa;
				xferAddr.sLong <= xferReq.isLong;
				xferAddr.sStore <= xferReq.isStore;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	a_xy_addr_lsb: assert property (
		xferAddr.xyValid |-> !xferAddr.xAddr[0] && !xferAddr.yAddr[0])
		else $error("X/Y address bit 0 is set");

	a_xy_same_cycle: assert property (
		doXY |=> xferAddr.xyValid && !xferAddr.sValid
		&& xferAddr.xAddr[15:1] == $past(xPtr[15:1]))
		else $error("X/Y addresses not issued together");

	a_xy_inc_step: assert property (
		doXY && xferReq.mode == MODE_INC && !xHit
		|=> ptr[$past(xIdx)][15:0] == $past(xPtr[15:0]) + 16'h0002)
		else $error("X pointer did not step by 2");

	a_xy_upper_kept: assert property (
		doXY |=> ptr[$past(yIdx)][31:16] == $past(yPtr[31:16]))
		else $error("Y pointer upper half changed");

	a_wrap_load: assert property (
		xyUpd && xHit
		|=> ptr[$past(xIdx)][15:1] == $past(wrapStart[15:1]))
		else $error("X pointer did not wrap to start");

	a_y_wrap_load: assert property (
		xyUpd && yHit
		|=> ptr[$past(yIdx)][15:0]
		== {$past(wrapStart[15:1]), $past(yPtr[0])})
		else $error("Y pointer did not wrap to start");

	a_x_step_past: assert property (
		doXY && xferReq.mode == MODE_INDEX && !xHit
		|=> ptr[$past(xIdx)][15:0]
		== $past(xPtr[15:0]) + $past(ptr[X_INDEX_IDX][15:0]))
		else $error("X pointer wrapped without an end match");

	a_xy_hold: assert property (
		doXY && xferReq.mode == MODE_NONE && !regWr
		|=> ptr[$past(xIdx)] == $past(xPtr)
		&& ptr[$past(yIdx)] == $past(yPtr))
		else $error("Paired no-update changed a pointer");

	a_index_add: assert property (
		doXY && xferReq.mode == MODE_INDEX && !yHit
		|=> ptr[$past(yIdx)][15:0]
		== $past(yPtr[15:0] + ptr[Y_INDEX_IDX][15:0]))
		else $error("Y pointer index add wrong");

	a_single_dec: assert property (
		doS && xferReq.mode == MODE_DEC
		|=> xferAddr.sAddr == $past(sPtr - sStep)
		&& ptr[$past(sIdx)] == xferAddr.sAddr)
		else $error("Single decrement address wrong");

	a_single_nowrap: assert property (
		doS && xferReq.mode == MODE_INC
		|=> ptr[$past(sIdx)] == $past(sPtr) + $past(sStep))
		else $error("Single increment wrapped or missed");

	a_single_index: assert property (
		doS && xferReq.mode == MODE_INDEX
		|=> ptr[$past(sIdx)] == $past(sPtr) + $past(ptr[S_STEP_IDX]))
		else $error("Single index add wrong");

	a_single_post: assert property (
		doS && xferReq.mode != MODE_DEC
		|=> xferAddr.sAddr == $past(sPtr))
		else $error("Single post-update address wrong");

	a_paired_free: assert property (
		xferReq.paired |-> xferReady)
		else $error("Paired transfer waited on the main bus");

	a_status_refused: assert property (
		regWr && regAddr == REG_ADDR_W'(OFF_STATUS_WORD)
		&& regWData[STAT_XWRAP_BIT] && regWData[STAT_YWRAP_BIT]
		|=> xWrapEn == $past(xWrapEn) && yWrapEn == $past(yWrapEn))
		else $error("Status write with both enables was taken");

	a_wrap_exclusive: assert property (
		!(xWrapEn && yWrapEn))
		else $error("Both wrap enables set");

	a_main_wait: assert property (
		xferReq.valid && !xferReq.paired && mainBusy
		|-> !xferReady ##1 !xferAddr.sValid)
		else $error("Single transfer taken while bus busy");

	a_bounds_read: assert property (
		regRd && regAddr == REG_ADDR_W'(OFF_WRAP_BOUNDS) && !regWr
		|=> regRData == $past(wrapBounds))
		else $error("Wrap bounds read back wrong");

	c_x_wrap: cover property (doXY && xHit && xferReq.mode == MODE_INC);
	c_y_index: cover property (doXY && xferReq.mode == MODE_INDEX);
	c_y_wrap: cover property (xyUpd && yHit);
	c_long_dec: cover property (doS && xferReq.isLong
		&& xferReq.mode == MODE_DEC);
	c_bus_wait: cover property (xferReq.valid && !xferReq.paired
		&& mainBusy ##1 doS);
endmodule

// ---- tb/main_bus_model.sv ----
// Main bus model that holds the bus busy at random times
`timescale 1ns/1ns
module main_bus_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Control
	input wire logic stallEn,
	// Bus state
	output logic mainBusy
);
	int seed = 1572;
	// Single transfers contend here and must wait
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mainBusy <= 1'b0;
		end else begin
			mainBusy <= stallEn && (($random(seed) & 3) == 0);
		end
	end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench of the DSP address generator
`timescale 1ns/1ns
module tb_top;
	import dsp_agu_pkg::*;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWData = 32'h0000_0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRData;
	xferReq_t xferReq = '0;
	logic xferReady;
	logic mainBusy;
	xferAddr_t xferAddr;
	logic stallEn = 1'b0;
	logic [31:0] ptr [0:7];
	logic [31:0] bounds;
	logic xw;
	logic yw;
	int seed = 1572;
	int bad_count = 0;
	int total_checks = 0;
	always #5 sys_clk = ~sys_clk;
	dsp_address_generator #(.REG_ADDR_W(8)) u_dut (
		.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
		.regWData(regWData), .regWr(regWr), .regRd(regRd),
		.regRData(regRData), .xferReq(xferReq), .xferReady(xferReady),
		.mainBusy(mainBusy), .xferAddr(xferAddr)
	);
	main_bus_model u_bus (
		.sys_clk(sys_clk), .rstn(rstn), .stallEn(stallEn),
		.mainBusy(mainBusy)
	);
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWData <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
		if (a < 8'h20) ptr[a[4:2]] = d;
		if (a == 8'h20) bounds = d;
		if (a == 8'h24 && !(d[0] && d[1])) {yw, xw} = d[1:0];
	endtask
	task automatic reg_read(input logic [7:0] a);
		logic [31:0] e;
		e = 32'h0000_0000;
		if (a < 8'h20) e = ptr[a[4:2]];
		if (a == 8'h20) e = bounds;
		if (a == 8'h24) e = {30'h0, yw, xw};
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(negedge sys_clk);
		chk(regRData, e);
	endtask
	// ----------------------------------------------------------------
	// Transfers and expected pointer updates
	// ----------------------------------------------------------------
	function automatic logic [31:0] upd(logic [31:0] p, logic [31:0] i,
		logic w, updMode_t m);
		logic [15:0] lo;
		lo = p[15:0];
		if (m == MODE_INC) lo = p[15:0] + 16'h0002;
		if (m == MODE_INDEX) lo = p[15:0] + i[15:0];
		if (w && (m == MODE_INC || m == MODE_INDEX) && p[15:0] == bounds[31:16])
			lo = {bounds[15:1], p[0]};
		return {p[31:16], lo};
	endfunction
	function automatic xferReq_t mk(logic pr, logic xs, logic ys,
		logic [1:0] ss, updMode_t m, logic lg, logic st);
		return '{1'b1, pr, xs, ys, ss, m, lg, st};
	endfunction
	task automatic xfer(input xferReq_t r);
		int n;
		logic [2:0] xi;
		logic [2:0] yi;
		logic [31:0] ea;
		logic [31:0] stp;
		n = 0;
		@(posedge sys_clk);
		xferReq <= r;
		@(negedge sys_clk);
		while (xferReady !== 1'b1) begin
			n++;
			if (n > 50) begin
				bad_count++;
				$display("MISMATCH t=%0t request never taken", $time);
				final_report();
			end
			@(negedge sys_clk);
		end
		@(posedge sys_clk);
		xferReq.valid <= 1'b0;
		@(negedge sys_clk);
		if (r.paired) begin
			xi = 3'h2 + {2'b00, r.xSel};
			yi = 3'h4 + {2'b00, r.ySel};
			chk({xferAddr.xyValid, xferAddr.sValid}, 2'b10);
			chk(xferAddr.xAddr, {ptr[xi][15:1], 1'b0});
			chk(xferAddr.yAddr, {ptr[yi][15:1], 1'b0});
			ptr[xi] = upd(ptr[xi], ptr[6], xw, r.mode);
			ptr[yi] = upd(ptr[yi], ptr[7], yw, r.mode);
		end else begin
			stp = r.isLong ? 32'h0000_0004 : 32'h0000_0002;
			if (r.mode == MODE_DEC) ptr[r.sSel] = ptr[r.sSel] - stp;
			ea = ptr[r.sSel];
			if (r.mode == MODE_INC) ptr[r.sSel] = ptr[r.sSel] + stp;
			if (r.mode == MODE_INDEX) ptr[r.sSel] = ptr[r.sSel] + ptr[6];
			chk({xferAddr.xyValid, xferAddr.sValid}, 2'b01);
			chk(xferAddr.sAddr, ea);
			chk({xferAddr.sLong, xferAddr.sStore}, {r.isLong, r.isStore});
		end
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		for (int i = 0; i < 8; i++) ptr[i] = 32'h0000_0000;
		bounds = 32'h0000_0000;
		{yw, xw} = 2'b00;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int a = 0; a <= 8'h28; a += 4) reg_read(8'(a));
		reg_write(8'h28, 32'hFFFF_FFFF);
		reg_read(8'h28);
		reg_write(8'h20, 32'h700C_7008);
		reg_write(8'h24, 32'h0000_0001);
		reg_write(8'h24, 32'h0000_0003);
		reg_read(8'h24);
		reg_write(8'h08, 32'hA500_7008);
		reg_write(8'h10, 32'h0000_0100);
		repeat (4) xfer(mk(1, 0, 0, 0, MODE_INC, 0, 0));
		reg_read(8'h08);
		reg_write(8'h18, 32'h0000_0006);
		reg_write(8'h1C, 32'h0000_FFFE);
		repeat (4) xfer(mk(1, 0, 1, 0, MODE_INDEX, 0, 1));
		xfer(mk(1, 1, 1, 0, MODE_NONE, 0, 0));
		xfer(mk(1, 1, 0, 0, MODE_DEC, 0, 0));
		reg_read(8'h08);
		reg_write(8'h00, 32'h0000_700C);
		for (int m = 0; m < 8; m++) begin
			xfer(mk(0, 0, 0, 0, updMode_t'(m[1:0]), m[2], m[0]));
		end
		reg_read(8'h00);
		stallEn = 1'b1;
		repeat (300) begin
			if (($random(seed) & 7) == 0) begin
				reg_write(8'(($random(seed) & 7) * 4),
					$random(seed) & 32'hFFFF_FFFE);
				reg_write(8'h24, $random(seed) & 3);
				reg_write(8'h20, $random(seed) & 32'hFFFE_FFFE);
			end
			xfer(mk(1'($random(seed)), 1'($random(seed)),
				1'($random(seed)), 2'($random(seed)),
				updMode_t'($random(seed) & 3), 1'($random(seed)),
				1'($random(seed))));
		end
		for (int a = 0; a <= 8'h24; a += 4) reg_read(8'(a));
		final_report();
	end
endmodule
